// file: hw/rtc_serial_regs.v
`timescale 1ns/10ps
`include "rtc_map_defs.vh"
// Overview of operation
// - Four-bit address selects sixteen 4-bit registers
// - Alarm bank addresses 0,1 hold weekday selects
// - Every implemented bit but control one bits 0,1 is readable and writable
// - Unimplemented bits read zero, ignore writes
// - Control one bit0: adjust on write, busy on read
// - Control one bit1: carry enable / halt flag
// - Bank bit picks counters or alarms at 0-5
// - Addresses 7, E, F ignore bank bit
// - Chip enable low forces carry, test to one
// - Data pin floats while chip enable low
// - Control bits, then address, then data
// - Variant picks sampling and driving edges
// - Control one write clears halt flag while oscillator runs
module rtc_serial_regs #(
	parameter WRITE_ON_RISE = 0  // 0: sample falling, drive rising
) (
	input  wire       ref_clk,            // 25 MHz system clock
	input  wire       rstn,               // Async reset, active low
	input  wire       chip_enable,        // Link select pin, high active
	input  wire       shift_clk,          // Link shift clock pin
	input  wire       serial_data_i,      // Data pin input
	output reg        serial_data_o,      // Data pin output
	output reg        serial_data_oe_n,   // Data pin enable, low drives
	input  wire       osc_running,        // Oscillator alive indication
	input  wire       counter_busy_flag,  // Counter update in progress
	input  wire       irq_flag_set,       // Periodic interrupt event
	input  wire       alarm_flag_set,     // Alarm match event
	output reg        seconds_adjust_request, // Adjust pulse
	output wire       carry_enable,       // One-second carry enable
	output wire       osc_halt_flag,      // Oscillator halt seen
	output wire       periodic_irq_flag,  // Periodic interrupt flag
	output wire       alarm_match_flag,   // Alarm match flag
	output wire       bank_sel,           // Current bank
	output wire       hour24_sel,         // 12/24-hour select
	output wire       test_n,             // Test control, active low
	output wire [3:0] periodic_irq_select // Interrupt cycle setting
);
	localparam ST_IDLE = 2'd0;
	localparam ST_CTRL = 2'd1;
	localparam ST_ADDR = 2'd2;
	localparam ST_DATA = 2'd3;

	wire       ce_lvl;
	wire       sclk_rise;
	wire       sclk_fall;
	wire       sdi_lvl;
	wire       sample_edge;
	wire       drive_edge;
	reg  [1:0] state_r;
	reg  [1:0] cnt_r;
	reg  [3:0] ctrl_sr_r;
	reg  [3:0] addr_r;
	reg  [3:0] data_sr_r;
	reg  [3:0] rd_sr_r;
	reg        is_read_r;
	// Write decode, valid for one cycle at the last data bit
	reg        wr_done;
	reg  [3:0] wr_word;
	reg        wr_pctrl;
	reg        wr_sctrl;
	reg        wr_alarm;
	reg        wr_cnt;
	reg  [3:0] cnt_regs_r [0:15];
	reg  [3:0] alarm_regs_r [0:5];
	reg  [3:0] pctrl_r;
	reg  [3:0] sctrl_r;
	reg  [3:0] rd_word;

	// Pins lag about four clocks; link halves must be longer
	link_sync u_ce (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in (chip_enable),
		.level_r  (ce_lvl),
		.rise     (),
		.fall     ()
	);
	link_sync u_sclk (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in (shift_clk),
		.level_r  (),
		.rise     (sclk_rise),
		.fall     (sclk_fall)
	);
	link_sync u_sdi (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.async_in (serial_data_i),
		.level_r  (sdi_lvl),
		.rise     (),
		.fall     ()
	);

	assign sample_edge = WRITE_ON_RISE ? sclk_rise : sclk_fall;
	assign drive_edge  = WRITE_ON_RISE ? sclk_fall : sclk_rise;

	// Implemented-bit mask per address and bank
	function [3:0] impl_mask;
		input [3:0] a;
		input       bank;
		begin
			impl_mask = 4'hf;
			case (a)
			`ADDR_SEC_TENS:  impl_mask = bank ? 4'hf : `MASK_SEC_TENS;
			`ADDR_MIN_TENS:  impl_mask = bank ? `MASK_AL_MIN_TENS
				: `MASK_MIN_TENS;
			`ADDR_HOUR_TENS: impl_mask = bank ? `MASK_AL_HOUR_TENS
				: `MASK_HOUR_TENS;
			`ADDR_WEEKDAY:   impl_mask = `MASK_WEEKDAY;
			`ADDR_DAY_TENS:  impl_mask = `MASK_DAY_TENS;
			`ADDR_MON_TENS:  impl_mask = `MASK_MON_TENS;
			`ADDR_SECONDARY_CTRL: impl_mask = `MASK_SECONDARY_CTRL;
			default:         impl_mask = 4'hf;
			endcase
		end
	endfunction

	// Bank applies only below the weekday counter
	function in_alarm_bank;
		input [3:0] a;
		input       bank;
		begin
			in_alarm_bank = bank && (a <= `ADDR_HOUR_TENS);
		end
	endfunction

	// True on the last bit of a four-bit field
	function field_last;
		input [1:0] c;
		begin
			field_last = (c == 2'h3);
		end
	endfunction

	assign carry_enable        = pctrl_r[`BIT_CARRY_HALT];
	assign periodic_irq_flag   = pctrl_r[`BIT_IRQ_FLAG];
	assign alarm_match_flag    = pctrl_r[`BIT_ALARM_FLAG];
	assign bank_sel            = sctrl_r[`BIT_BANK];
	assign hour24_sel          = sctrl_r[`BIT_HOUR24];
	assign test_n              = sctrl_r[`BIT_TEST_N];
	assign periodic_irq_select = cnt_regs_r[`ADDR_IRQ_SELECT];

	reg halt_r;
	assign osc_halt_flag = halt_r;

	// Read data multiplexer
	always @* begin
		rd_word = 4'h0;
		if (addr_r == `ADDR_PRIMARY_CTRL) begin
			rd_word = pctrl_r;
			rd_word[`BIT_ADJ_BUSY]   = counter_busy_flag;
			rd_word[`BIT_CARRY_HALT] = halt_r;
		end else if (addr_r == `ADDR_SECONDARY_CTRL)
			rd_word = sctrl_r & `MASK_SECONDARY_CTRL;
		else if (in_alarm_bank(addr_r, bank_sel))
			rd_word = alarm_regs_r[addr_r[2:0]]
				& impl_mask(addr_r, 1'b1);
		else
			rd_word = cnt_regs_r[addr_r]
				& impl_mask(addr_r, 1'b0);
	end

	// Write decode: one commit per frame, on the last data bit
	always @* begin
		wr_word  = {sdi_lvl, data_sr_r[3:1]};
		wr_done  = ce_lvl && state_r == ST_DATA && !is_read_r
			&& sample_edge && field_last(cnt_r);
		wr_pctrl = 1'b0;
		wr_sctrl = 1'b0;
		wr_alarm = 1'b0;
		wr_cnt   = 1'b0;
		// Bank bit is taken as it stands when the frame ends
		if (wr_done) begin
			if (addr_r == `ADDR_PRIMARY_CTRL)
				wr_pctrl = 1'b1;
			else if (addr_r == `ADDR_SECONDARY_CTRL)
				wr_sctrl = 1'b1;
			else if (in_alarm_bank(addr_r, bank_sel))
				wr_alarm = 1'b1;
			else
				wr_cnt = 1'b1;
		end
	end

	// Frame sequencer; chip enable low abandons a partial frame
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r   <= ST_IDLE;
			cnt_r     <= 2'h0;
			ctrl_sr_r <= 4'h0;
			addr_r    <= 4'h0;
			data_sr_r <= 4'h0;
			is_read_r <= 1'b0;
		end else if (!ce_lvl) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
			ST_IDLE: begin
				state_r <= ST_CTRL;
				cnt_r   <= 2'h0;
			end
			ST_CTRL: if (sample_edge) begin
				ctrl_sr_r <= {ctrl_sr_r[2:0], sdi_lvl};
				cnt_r     <= cnt_r + 2'h1;
				if (field_last(cnt_r))
					state_r <= ST_ADDR;
			end
			ST_ADDR: if (sample_edge) begin
				addr_r <= {addr_r[2:0], sdi_lvl};
				cnt_r  <= cnt_r + 2'h1;
				// Only the first control bit matters: one reads
				if (field_last(cnt_r)) begin
					state_r   <= ST_DATA;
					is_read_r <= ctrl_sr_r[3];
				end
			end
			ST_DATA: if (!is_read_r && sample_edge) begin
				data_sr_r <= wr_word;
				cnt_r     <= cnt_r + 2'h1;
				if (field_last(cnt_r))
					state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Read shifter; the first drive edge turns the pin round
	// Bits leave LSB first; extra edges shift out zeros
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			serial_data_o    <= 1'b0;
			serial_data_oe_n <= 1'b1;
			rd_sr_r          <= 4'h0;
		end else if (!ce_lvl) begin
			serial_data_oe_n <= 1'b1;
		end else if (state_r == ST_DATA && is_read_r
			&& drive_edge) begin
			serial_data_oe_n <= 1'b0;
			if (serial_data_oe_n) begin
				serial_data_o <= rd_word[0];
				rd_sr_r       <= {1'b0, rd_word[3:1]};
			end else begin
				serial_data_o <= rd_sr_r[0];
				rd_sr_r       <= {1'b0, rd_sr_r[3:1]};
			end
		end
	end

	// Control registers
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pctrl_r                <= `RST_PRIMARY_CTRL;
			sctrl_r                <= `RST_SECONDARY_CTRL;
			halt_r                 <= 1'b1;
			seconds_adjust_request <= 1'b0;
		end else begin
			seconds_adjust_request <= wr_pctrl
				& wr_word[`BIT_ADJ_BUSY];
			if (wr_pctrl) begin
				pctrl_r[3:1] <= wr_word[3:1];
				if (osc_running)
					halt_r <= 1'b0;
			end
			if (wr_sctrl)
				sctrl_r <= wr_word
					& `MASK_SECONDARY_CTRL;
			// Deselected: carry and test forced, halt sensing live
			if (!ce_lvl) begin
				pctrl_r[`BIT_CARRY_HALT] <= 1'b1;
				sctrl_r[`BIT_TEST_N]     <= 1'b1;
				if (!osc_running)
					halt_r <= 1'b1;
			end
			// Placed last so a same-cycle event beats a host clear
			if (irq_flag_set)
				pctrl_r[`BIT_IRQ_FLAG] <= 1'b1;
			if (alarm_flag_set)
				pctrl_r[`BIT_ALARM_FLAG] <= 1'b1;
		end
	end

	// Register file; masks drop writes to unimplemented bits
	// Slots E and F stay unused, control lives apart
	integer i;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (i = 0; i < 16; i = i + 1)
				cnt_regs_r[i] <= 4'h0;
			for (i = 0; i < 6; i = i + 1)
				alarm_regs_r[i] <= 4'h0;
		end else if (wr_alarm) begin
			alarm_regs_r[addr_r[2:0]] <= wr_word
				& impl_mask(addr_r, 1'b1);
		end else if (wr_cnt) begin
			cnt_regs_r[addr_r] <= wr_word
				& impl_mask(addr_r, 1'b0);
		end
	end
endmodule // rtc_serial_regs

// file: include/rtc_map_defs.vh
`ifndef RTC_MAP_DEFS_VH
`define RTC_MAP_DEFS_VH
// Register addresses
`define ADDR_SEC_UNITS      4'h0
`define ADDR_SEC_TENS       4'h1
`define ADDR_MIN_UNITS      4'h2
`define ADDR_MIN_TENS       4'h3
`define ADDR_HOUR_UNITS     4'h4
`define ADDR_HOUR_TENS      4'h5
`define ADDR_WEEKDAY        4'h6
`define ADDR_IRQ_SELECT     4'h7
`define ADDR_DAY_UNITS      4'h8
`define ADDR_DAY_TENS       4'h9
`define ADDR_MON_UNITS      4'ha
`define ADDR_MON_TENS       4'hb
`define ADDR_YEAR_UNITS     4'hc
`define ADDR_YEAR_TENS      4'hd
`define ADDR_PRIMARY_CTRL   4'he
`define ADDR_SECONDARY_CTRL 4'hf
// Implemented-bit masks, counter bank
`define MASK_SEC_TENS       4'h7
`define MASK_MIN_TENS       4'h7
`define MASK_HOUR_TENS      4'h3
`define MASK_WEEKDAY        4'h7
`define MASK_DAY_TENS       4'h3
`define MASK_MON_TENS       4'h1
// Implemented-bit masks, alarm bank and secondary control
`define MASK_AL_MIN_TENS    4'h7
`define MASK_AL_HOUR_TENS   4'hb
`define MASK_SECONDARY_CTRL 4'hb
// Control field positions
`define BIT_ADJ_BUSY        0
`define BIT_CARRY_HALT      1
`define BIT_ALARM_FLAG      2
`define BIT_IRQ_FLAG        3
`define BIT_TEST_N          0
`define BIT_BANK            1
`define BIT_HOUR24          3
// Reset values
`define RST_PRIMARY_CTRL    4'h2
`define RST_SECONDARY_CTRL  4'h1
// Frame field lengths in shift-clock bits
`define CTRL_BITS           4
`define ADDR_BITS           4
`define DATA_BITS           4
`endif

// file: hw/link_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; change accepted when stages two and three agree
module link_sync (
	input  wire ref_clk,   // System clock
	input  wire rstn,      // Async reset, active low
	input  wire async_in,  // Pin level
	output reg  level_r,   // Filtered level
	output wire rise,      // One-cycle pulse on accepted rise
	output wire fall       // One-cycle pulse on accepted fall
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg prev_r;

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			s1_r   <= async_in;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			prev_r <= level_r;
			if (s2_r == s3_r)
				level_r <= s3_r;
		end
	end

	assign rise = level_r & ~prev_r;
	assign fall = ~level_r & prev_r;
endmodule // link_sync

// file: test/rtc_host_bfm.sv
`timescale 1ns/10ps
module rtc_host_bfm #(
	parameter logic INV = 1'b0    // 1: inverted shift clock variant
) (
	input  wire  ref_clk,         // Clock
	output logic chip_enable,     // Select
	output logic shift_clk,       // Idles at INV
	output wire  serial_data_i,   // Wire level
	input  wire  serial_data_o,   // Device data
	input  wire  serial_data_oe_n // Low: device drives
);
	logic hd = 1'b0;
	// Released wire shows a toggling level, not the last bit
	assign serial_data_i = serial_data_oe_n ? hd : serial_data_o;
	initial begin
		chip_enable = 1'b0;
		shift_clk = INV;
	end
	task automatic half;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic xfer(input logic rd, input logic [3:0] a, wd,
		output logic [3:0] q);
		logic [11:0] sh;
		sh = {rd, 3'b000, a, wd[0], wd[1], wd[2], wd[3]};
		chip_enable = 1'b1;
		half;
		for (int i = 11; i >= 0; i--) begin
			hd = (rd && i < 4) ? ~hd : sh[i];
			shift_clk = ~INV;
			half;
			shift_clk = INV;
			half;
			if (rd && i < 4)
				q[3 - i] = serial_data_i;
		end
		half;
		chip_enable = 1'b0;
		hd = ~hd;
		repeat (3) half;
	endtask
endmodule // rtc_host_bfm

// file: test/rtc_serial_regs_sva.sv
`timescale 1ns/10ps
module rtc_regs_chk (
	input wire       ref_clk,   // Clock
	input wire       rstn,      // Reset
	input wire       chip_enable,            // Select pin
	input wire       osc_running,            // Oscillator alive
	input wire       irq_flag_set,           // Periodic event
	input wire       alarm_flag_set,         // Alarm event
	input wire       serial_data_oe_n,       // Pin enable
	input wire       seconds_adjust_request, // Adjust pulse
	input wire       carry_enable,           // Carry enable
	input wire       osc_halt_flag,          // Halt flag
	input wire       periodic_irq_flag,      // Periodic flag
	input wire       alarm_match_flag,       // Alarm flag
	input wire       bank_sel,               // Bank
	input wire       hour24_sel,             // 12/24 select
	input wire       test_n,                 // Test, active low
	input wire [3:0] periodic_irq_select     // Cycle setting
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// Six cycles covers the pin synchroniser lag
	sequence s_idle;
		!chip_enable [*6];
	endsequence
	property p_float; s_idle |-> serial_data_oe_n; endproperty
	a_float: assert property (p_float) else $error("pin driven");
	property p_force; s_idle |-> carry_enable && test_n; endproperty
	a_force: assert property (p_force) else $error("no force");
	property p_idle;
		s_idle |-> $stable({periodic_irq_select, bank_sel, hour24_sel});
	endproperty
	a_idle: assert property (p_idle) else $error("idle write");
	property p_adj1; seconds_adjust_request |=> !seconds_adjust_request;
	endproperty
	a_adj1: assert property (p_adj1) else $error("adjust long");
	property p_adjce; seconds_adjust_request |-> chip_enable; endproperty
	a_adjce: assert property (p_adjce) else $error("adjust idle");
	property p_irq; irq_flag_set |-> ##[1:3] periodic_irq_flag; endproperty
	a_irq: assert property (p_irq) else $error("irq flag");
	property p_alm; alarm_flag_set |-> ##[1:3] alarm_match_flag;
	endproperty
	a_alm: assert property (p_alm) else $error("alarm flag");
	property p_hclr; $fell(osc_halt_flag) |-> chip_enable && osc_running;
	endproperty
	a_hclr: assert property (p_hclr) else $error("halt clear");
	property p_hset; $rose(osc_halt_flag) |-> !osc_running; endproperty
	a_hset: assert property (p_hset) else $error("halt set");
	property p_cen; $fell(carry_enable) |-> chip_enable; endproperty
	a_cen: assert property (p_cen) else $error("carry idle");
	c_adj: cover property (seconds_adjust_request);
	c_hclr: cover property ($fell(osc_halt_flag));
	c_bank: cover property ($rose(bank_sel));
endmodule // rtc_regs_chk
bind rtc_serial_regs rtc_regs_chk i_chk (.ref_clk, .rstn, .chip_enable,
	.osc_running, .irq_flag_set, .alarm_flag_set, .serial_data_oe_n,
	.seconds_adjust_request, .carry_enable, .osc_halt_flag,
	.periodic_irq_flag, .alarm_match_flag, .bank_sel, .hour24_sel,
	.test_n, .periodic_irq_select);

// file: test/tb_rtc_serial_regs.sv
`timescale 1ns/10ps
module tb_rtc_serial_regs;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic osc_running = 1'b1;
	logic counter_busy_flag = 1'b0;
	logic irq_flag_set = 1'b0;
	logic alarm_flag_set = 1'b0;
	wire  chip_enable, shift_clk, serial_data_i, serial_data_o;
	wire  serial_data_oe_n, bank_sel, hour24_sel, test_n;
	wire  ce_b, sclk_b, sdi_b, sdo_b, oe_n_b;
	logic use_b = 1'b0;
	int   n_fail = 0;
	int   tests_run = 0;
	logic [3:0] m0 [14] = '{4'hf, 4'h7, 4'hf, 4'h7, 4'hf, 4'h3, 4'h7,
		4'hf, 4'hf, 4'h3, 4'hf, 4'h1, 4'hf, 4'hf};
	logic [3:0] m1 [6] = '{4'hf, 4'hf, 4'hf, 4'h7, 4'hf, 4'hb};
	always #20 ref_clk = ~ref_clk;
	rtc_host_bfm i_host (.ref_clk, .chip_enable, .shift_clk,
		.serial_data_i, .serial_data_o, .serial_data_oe_n);
	rtc_serial_regs i_dut (.ref_clk, .rstn, .chip_enable, .shift_clk,
		.serial_data_i, .serial_data_o, .serial_data_oe_n, .osc_running,
		.counter_busy_flag, .irq_flag_set, .alarm_flag_set,
		.seconds_adjust_request(), .carry_enable(), .osc_halt_flag(),
		.periodic_irq_flag(), .alarm_match_flag(), .bank_sel, .hour24_sel,
		.test_n, .periodic_irq_select());
	rtc_host_bfm #(.INV(1'b1)) i_host_b (.ref_clk, .chip_enable(ce_b),
		.shift_clk(sclk_b), .serial_data_i(sdi_b), .serial_data_o(sdo_b),
		.serial_data_oe_n(oe_n_b));
	rtc_serial_regs #(.WRITE_ON_RISE(1)) i_dut_b (.ref_clk, .rstn,
		.chip_enable(ce_b), .shift_clk(sclk_b), .serial_data_i(sdi_b),
		.serial_data_o(sdo_b), .serial_data_oe_n(oe_n_b), .osc_running,
		.counter_busy_flag, .irq_flag_set, .alarm_flag_set,
		.seconds_adjust_request(), .carry_enable(), .osc_halt_flag(),
		.periodic_irq_flag(), .alarm_match_flag(), .bank_sel(),
		.hour24_sel(), .test_n(), .periodic_irq_select());
	task automatic chk(input string nm, input logic [3:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, d);
		logic [3:0] q;
		if (use_b)
			i_host_b.xfer(1'b0, a, d, q);
		else
			i_host.xfer(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, exp);
		logic [3:0] q;
		if (use_b)
			i_host_b.xfer(1'b1, a, 4'h0, q);
		else
			i_host.xfer(1'b1, a, 4'h0, q);
		chk($sformatf("reg %h", a), q, exp);
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (2) @(negedge ref_clk);
		rd(4'he, 4'h2);
		rd(4'hf, 4'h1);
		wr(4'hf, 4'he);
		chk("ctrl pins", {hour24_sel, 1'b0, bank_sel, test_n}, 4'hb);
		rd(4'hf, 4'hb);
		for (int a = 0; a < 6; a++) begin
			wr(a[3:0], 4'hf);
			rd(a[3:0], m1[a]);
		end
		wr(4'h7, 4'hf);
		rd(4'h7, 4'hf);
		wr(4'hf, 4'h1);
		// Counters untouched by alarm-bank writes
		for (int a = 0; a < 6; a++)
			rd(a[3:0], 4'h0);
		for (int a = 0; a < 14; a++) begin
			wr(a[3:0], 4'hf);
			rd(a[3:0], m0[a]);
		end
		wr(4'he, 4'h0);
		rd(4'he, 4'h0);
		counter_busy_flag = 1'b1;
		rd(4'he, 4'h1);
		wr(4'he, 4'h1);
		osc_running = 1'b0;
		repeat (20) @(negedge ref_clk);
		osc_running = 1'b1;
		irq_flag_set = 1'b1;
		alarm_flag_set = 1'b1;
		@(negedge ref_clk);
		irq_flag_set = 1'b0;
		alarm_flag_set = 1'b0;
		rd(4'he, 4'hf);
		wr(4'he, 4'h0);
		rd(4'he, 4'h1);
		// Inverted shift clock variant
		use_b = 1'b1;
		wr(4'h8, 4'h9);
		rd(4'h8, 4'h9);
		wr(4'h5, 4'hf);
		rd(4'h5, 4'h3);
		wrap_up;
	end
endmodule // tb_rtc_serial_regs
